/* pkg/ais_pkg.sv */
// package for the converter input select and timing block
package ais_pkg;
  // ----------------------------------------
  // register byte addresses (apb, one word each)
  // ----------------------------------------
  localparam logic [7:0] ADDR_TIMING = 8'h00;
  localparam logic [7:0] ADDR_DEPTH = 8'h04;
  localparam logic [7:0] ADDR_AUX_SEL = 8'h08;
  localparam logic [7:0] ADDR_PRI_SEL = 8'h0c;
  localparam logic [7:0] ADDR_SCAN = 8'h10;
  localparam logic [7:0] ADDR_CTRL = 8'h14;
  localparam logic [7:0] ADDR_STATUS = 8'h18;
  // ----------------------------------------
  // implemented bit masks and reset values
  // ----------------------------------------
  localparam logic [15:0] MASK_TIMING = 16'h9fff;
  localparam logic [15:0] MASK_DEPTH = 16'h0007;
  localparam logic [15:0] MASK_AUX_SEL = 16'h0707;
  localparam logic [15:0] MASK_PRI_SEL = 16'h9f9f;
  localparam logic [15:0] MASK_SCAN = 16'h1fff;
  localparam logic [15:0] MASK_CTRL = 16'h00ff;
  localparam logic [15:0] RESET_VALUE = 16'h0000;
  // ----------------------------------------
  // field positions
  // ----------------------------------------
  localparam int TIM_SRC_BIT = 15;
  localparam int TIM_SAMP_LSB = 8;
  localparam int AUX_NEG_B_LSB = 9;
  localparam int AUX_POS_B_BIT = 8;
  localparam int AUX_NEG_A_LSB = 1;
  localparam int AUX_POS_A_BIT = 0;
  localparam int PRI_NEG_B_BIT = 15;
  localparam int PRI_POS_B_LSB = 8;
  localparam int PRI_NEG_A_BIT = 7;
  localparam int CTRL_RES_BIT = 0;
  localparam int CTRL_ALT_BIT = 1;
  localparam int CTRL_SCAN_BIT = 2;
  localparam int CTRL_TRIG_LSB = 3;
  localparam int CTRL_SMALL_BIT = 6;
  localparam int CTRL_START_BIT = 7;
  // ----------------------------------------
  // encodings
  // ----------------------------------------
  localparam logic [2:0] TRIG_AUTO = 3'h7;
  localparam logic [7:0] DIV_MAX = 8'h3f;
  localparam logic [4:0] INPUT_MAX = 5'h0c;
  localparam logic [4:0] NEG_REF = 5'h1f;
  localparam logic [1:0] NEG_SEL_HIGH = 2'h3;
  localparam logic [1:0] NEG_SEL_MID = 2'h2;
  localparam logic [3:0] RC_DIV = 4'h8;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_SAMPLE = 2'b01,
    ST_CONVERT = 2'b10
  } ais_state_t;
endpackage

/* rtl/ais_top.sv */
// converter clock, sample timing and input multiplexer select logic
module ais_top (
  input wire logic core_clk, // 250 mhz clock
  input wire logic rst_n, // synchronous reset, active low
  input wire logic psel, // apb select
  input wire logic penable, // apb enable
  input wire logic pwrite, // apb direction
  input wire logic [31:0] paddr, // apb address
  input wire logic [31:0] pwdata, // apb write data
  output logic [31:0] prdata, // apb read data
  output logic pready, // apb ready
  output logic pslverr, // apb error
  input wire logic rc_clk_tick, // one-cycle tick from rc oscillator
  input wire logic convert_done, // converter core finished conversion
  output logic sampling, // sample and hold tracking
  output logic convert_start, // pulse: start conversion
  output logic conv_clock_period, // pulse: one conversion clock period
  output logic [4:0] primary_pos_sel, // channel 0 positive input, 1f = ref
  output logic [4:0] primary_neg_sel, // channel 0 negative input, 1f = ref
  output logic [4:0] aux_pos_sel [3], // channels 1-3 positive inputs
  output logic [4:0] aux_neg_sel [3], // channels 1-3 negative inputs
  output logic [7:0] buffer_words_per_input, // words per input in dma buffer
  output logic resolution_mode // twelve-bit mode active
);
  // ----------------------------------------
  // registers
  // ----------------------------------------
  logic [15:0] timing_reg, depth_reg, aux_reg, pri_reg, scan_reg, ctrl_reg;
  logic [7:0] tad_cnt_reg;
  logic [4:0] samp_cnt_reg;
  logic [3:0] scan_idx_reg;
  logic sample_b_reg;
  ais_pkg::ais_state_t state_reg;
  logic wr_en, rd_en, addr_ok;
  logic tad_tick, use_b, small_variant, was_sampling_reg;
  logic [15:0] rd_data;
  logic [3:0] scan_next;

  assign wr_en = psel && penable && pwrite && addr_ok;
  assign rd_en = psel && penable && !pwrite;
  assign pready = 1'b1;
  assign small_variant = ctrl_reg[ais_pkg::CTRL_SMALL_BIT];
  assign resolution_mode = ctrl_reg[ais_pkg::CTRL_RES_BIT];

  // maps a requested input to the reference when absent or reserved
  function automatic logic [4:0] map_input(input logic [4:0] idx, input logic sm);
    if (idx > ais_pkg::INPUT_MAX) begin
      map_input = ais_pkg::NEG_REF;
    end else if (sm && idx >= 5'h06 && idx <= 5'h08) begin
      map_input = ais_pkg::NEG_REF;
    end else begin
      map_input = idx;
    end
  endfunction

  // aux negative decode for channel k
  function automatic logic [4:0] aux_neg(input logic [1:0] code, input int k,
                                         input logic sm);
    if (code == ais_pkg::NEG_SEL_HIGH) begin
      aux_neg = 5'(9 + k);
    end else if (code == ais_pkg::NEG_SEL_MID) begin
      aux_neg = map_input(5'(6 + k), sm);
    end else begin
      aux_neg = ais_pkg::NEG_REF;
    end
  endfunction

  // ----------------------------------------
  // apb register writes
  // ----------------------------------------
  // each write keeps only implemented bits so reserved ones stay zero
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      timing_reg <= ais_pkg::RESET_VALUE;
      depth_reg <= ais_pkg::RESET_VALUE;
      aux_reg <= ais_pkg::RESET_VALUE;
      pri_reg <= ais_pkg::RESET_VALUE;
      scan_reg <= ais_pkg::RESET_VALUE;
      ctrl_reg <= ais_pkg::RESET_VALUE;
    end else if (wr_en) begin
      unique case (paddr[7:0])
        ais_pkg::ADDR_TIMING: timing_reg <= pwdata[15:0] & ais_pkg::MASK_TIMING;
        ais_pkg::ADDR_DEPTH: depth_reg <= pwdata[15:0] & ais_pkg::MASK_DEPTH;
        ais_pkg::ADDR_AUX_SEL: aux_reg <= pwdata[15:0] & ais_pkg::MASK_AUX_SEL;
        ais_pkg::ADDR_PRI_SEL: pri_reg <= pwdata[15:0] & ais_pkg::MASK_PRI_SEL;
        ais_pkg::ADDR_SCAN: scan_reg <= pwdata[15:0] & ais_pkg::MASK_SCAN;
        ais_pkg::ADDR_CTRL: ctrl_reg <= pwdata[15:0] & ais_pkg::MASK_CTRL;
        default: ;
      endcase
    end
  end

  // ----------------------------------------
  // apb read mux
  // ----------------------------------------
  // upper address bits must be clear so no register aliases higher up
  assign addr_ok = (paddr[31:8] == 24'h000000) && (paddr[7:0] <= ais_pkg::ADDR_STATUS)
                   && (paddr[1:0] == 2'h0);
  always_comb begin
    rd_data = 16'h0000;
    unique case (paddr[7:0])
      ais_pkg::ADDR_TIMING: rd_data = timing_reg;
      ais_pkg::ADDR_DEPTH: rd_data = depth_reg;
      // aux selects read zero in twelve-bit mode
      ais_pkg::ADDR_AUX_SEL: rd_data = resolution_mode ? 16'h0000 : aux_reg;
      ais_pkg::ADDR_PRI_SEL: rd_data = pri_reg;
      ais_pkg::ADDR_SCAN: rd_data = scan_reg;
      ais_pkg::ADDR_CTRL: rd_data = ctrl_reg;
      ais_pkg::ADDR_STATUS: rd_data = {8'h00, sample_b_reg, scan_idx_reg,
                                       1'b0, state_reg};
      default: rd_data = 16'h0000;
    endcase
  end
  assign pslverr = psel && penable && !addr_ok;
  assign prdata = {16'h0000, addr_ok ? rd_data : 16'h0000};

  // ----------------------------------------
  // conversion clock period generator
  // ----------------------------------------
  // rc source counts its own ticks so divider code has no effect there
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      tad_cnt_reg <= 8'h00;
    end else if (timing_reg[ais_pkg::TIM_SRC_BIT]) begin
      tad_cnt_reg <= 8'h00;
    end else if (tad_cnt_reg >= (timing_reg[7:0] & ais_pkg::DIV_MAX)) begin
      tad_cnt_reg <= 8'h00;
    end else begin
      tad_cnt_reg <= tad_cnt_reg + 8'h01;
    end
  end
  // reserved codes above 63 keep only their low six bits
  assign tad_tick = timing_reg[ais_pkg::TIM_SRC_BIT] ? rc_clk_tick
                  : (tad_cnt_reg >= (timing_reg[7:0] & ais_pkg::DIV_MAX));
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      conv_clock_period <= 1'b0;
    end else begin
      conv_clock_period <= tad_tick;
    end
  end

  // ----------------------------------------
  // sample / convert sequencer
  // ----------------------------------------
  // start bit arms sampling; auto trigger ends it after the sample count
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      state_reg <= ais_pkg::ST_IDLE;
      samp_cnt_reg <= 5'h00;
    end else begin
      unique case (state_reg)
        ais_pkg::ST_IDLE: begin
          samp_cnt_reg <= 5'h00;
          if (ctrl_reg[ais_pkg::CTRL_START_BIT]) begin
            state_reg <= ais_pkg::ST_SAMPLE;
          end
        end
        ais_pkg::ST_SAMPLE: begin
          if (ctrl_reg[ais_pkg::CTRL_TRIG_LSB +: 3] == ais_pkg::TRIG_AUTO) begin
            if (samp_cnt_reg >= timing_reg[ais_pkg::TIM_SAMP_LSB +: 5]) begin
              state_reg <= ais_pkg::ST_CONVERT;
            end else if (tad_tick) begin
              samp_cnt_reg <= samp_cnt_reg + 5'h01;
            end
          end else if (!ctrl_reg[ais_pkg::CTRL_START_BIT]) begin
            state_reg <= ais_pkg::ST_CONVERT;
          end
        end
        ais_pkg::ST_CONVERT: begin
          samp_cnt_reg <= 5'h00;
          if (convert_done) begin
            state_reg <= ais_pkg::ST_IDLE;
          end
        end
        default: state_reg <= ais_pkg::ST_IDLE;
      endcase
    end
  end
  assign sampling = (state_reg == ais_pkg::ST_SAMPLE);
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      convert_start <= 1'b0;
      was_sampling_reg <= 1'b0;
    end else begin
      // pulse one cycle after sampling ends, whatever trigger ended it
      was_sampling_reg <= sampling;
      convert_start <= was_sampling_reg && !sampling;
    end
  end

  // ----------------------------------------
  // sample a / b alternation and scan pointer
  // ----------------------------------------
  // next enabled scan slot after the current one, wrapping
  always_comb begin
    scan_next = scan_idx_reg;
    for (int i = 12; i >= 1; i--) begin
      if (scan_reg[(32'(scan_idx_reg) + i) % 13]) begin
        scan_next = 4'((32'(scan_idx_reg) + i) % 13);
      end
    end
  end
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      sample_b_reg <= 1'b0;
      scan_idx_reg <= 4'h0;
    end else if (state_reg == ais_pkg::ST_CONVERT && convert_done) begin
      sample_b_reg <= ctrl_reg[ais_pkg::CTRL_ALT_BIT] && !sample_b_reg;
      if (ctrl_reg[ais_pkg::CTRL_SCAN_BIT] && !sample_b_reg) begin
        scan_idx_reg <= scan_next;
      end
    end
  end
  assign use_b = sample_b_reg;

  // ----------------------------------------
  // multiplexer select outputs
  // ----------------------------------------
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      primary_pos_sel <= 5'h00;
      primary_neg_sel <= ais_pkg::NEG_REF;
      for (int k = 0; k < 3; k++) begin
        aux_pos_sel[k] <= ais_pkg::NEG_REF;
        aux_neg_sel[k] <= ais_pkg::NEG_REF;
      end
    end else begin
      if (use_b) begin
        primary_pos_sel <= map_input(pri_reg[ais_pkg::PRI_POS_B_LSB +: 5], small_variant);
        primary_neg_sel <= pri_reg[ais_pkg::PRI_NEG_B_BIT] ? 5'h01 : ais_pkg::NEG_REF;
      end else begin
        if (ctrl_reg[ais_pkg::CTRL_SCAN_BIT]) begin
          primary_pos_sel <= scan_reg[scan_idx_reg] ? map_input(5'(scan_idx_reg), small_variant)
                                                    : ais_pkg::NEG_REF;
        end else begin
          primary_pos_sel <= map_input(pri_reg[4:0], small_variant);
        end
        primary_neg_sel <= pri_reg[ais_pkg::PRI_NEG_A_BIT] ? 5'h01 : ais_pkg::NEG_REF;
      end
      for (int k = 0; k < 3; k++) begin
        if (resolution_mode) begin
          aux_pos_sel[k] <= ais_pkg::NEG_REF;
          aux_neg_sel[k] <= ais_pkg::NEG_REF;
        end else if (use_b) begin
          aux_pos_sel[k] <= 5'(k + (aux_reg[ais_pkg::AUX_POS_B_BIT] ? 3 : 0));
          aux_neg_sel[k] <= aux_neg(aux_reg[ais_pkg::AUX_NEG_B_LSB +: 2], k, small_variant);
        end else begin
          aux_pos_sel[k] <= 5'(k + (aux_reg[ais_pkg::AUX_POS_A_BIT] ? 3 : 0));
          aux_neg_sel[k] <= aux_neg(aux_reg[ais_pkg::AUX_NEG_A_LSB +: 2], k, small_variant);
        end
      end
    end
  end
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      buffer_words_per_input <= 8'h01;
    end else begin
      buffer_words_per_input <= 8'h01 << depth_reg[2:0];
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  a_reserved_zero: assert property (@(posedge core_clk) disable iff (!rst_n)
    (timing_reg & ~ais_pkg::MASK_TIMING) == 16'h0000)
    else $error("reserved timing bits set");
  a_aux_read_zero: assert property (@(posedge core_clk) disable iff (!rst_n)
    rd_en && paddr[7:0] == ais_pkg::ADDR_AUX_SEL && resolution_mode |-> prdata == 0)
    else $error("aux select readable in twelve-bit mode");
  a_rc_ignores_div: assert property (@(posedge core_clk) disable iff (!rst_n)
    timing_reg[ais_pkg::TIM_SRC_BIT] |=> tad_cnt_reg == 8'h00)
    else $error("divider counting while rc selected");
  a_period_tick: assert property (@(posedge core_clk) disable iff (!rst_n)
    tad_tick |-> ##1 conv_clock_period)
    else $error("period pulse lost");
  a_auto_end: assert property (@(posedge core_clk) disable iff (!rst_n)
    sampling && ctrl_reg[5:3] == ais_pkg::TRIG_AUTO
    && samp_cnt_reg >= timing_reg[12:8] |=> state_reg == ais_pkg::ST_CONVERT)
    else $error("auto sample did not end");
  a_conv_pulse: assert property (@(posedge core_clk) disable iff (!rst_n)
    convert_start |-> $past(sampling, 2) && !$past(sampling))
    else $error("convert start without sample end");
  a_buffer_len: assert property (@(posedge core_clk) disable iff (!rst_n)
    depth_reg[2:0] == 3'h7 && $stable(depth_reg) |=> buffer_words_per_input == 8'h80)
    else $error("buffer length wrong");
  a_aux_twelve: assert property (@(posedge core_clk) disable iff (!rst_n)
    resolution_mode && $stable(resolution_mode) |=> aux_pos_sel[0] == ais_pkg::NEG_REF)
    else $error("aux select active in twelve-bit mode");
  // ----------------------------------------
  // sequencer and select checks
  // ----------------------------------------
  // end of sampling: high on one edge, low on the next
  sequence s_sample_end;
    sampling ##1 !sampling;
  endsequence
  a_start_follows: assert property (@(posedge core_clk) disable iff (!rst_n)
    s_sample_end |=> convert_start)
    else $error("no start pulse after sampling");
  // with alternate mode each finished conversion flips the sample set
  a_alt_toggle: assert property (@(posedge core_clk) disable iff (!rst_n)
    state_reg == ais_pkg::ST_CONVERT && convert_done && ctrl_reg[ais_pkg::CTRL_ALT_BIT]
    |=> sample_b_reg != $past(sample_b_reg))
    else $error("sample set did not alternate");
  // absent inputs never reach the multiplexer once the variant bit has settled
  a_small_reserved: assert property (@(posedge core_clk) disable iff (!rst_n)
    small_variant && $stable(small_variant)
    |-> primary_pos_sel < 5'h06 || primary_pos_sel > 5'h08)
    else $error("absent input selected on small variant");
  // after each step the scan pointer stops on an enabled slot, if any is enabled
  a_scan_lands: assert property (@(posedge core_clk) disable iff (!rst_n)
    state_reg == ais_pkg::ST_CONVERT && convert_done && ctrl_reg[ais_pkg::CTRL_SCAN_BIT]
    && !sample_b_reg && scan_reg != 16'h0000 && $stable(scan_reg)
    |=> scan_reg[scan_idx_reg])
    else $error("scan pointer on a skipped input");
endmodule

/* verification/ais_core_model.sv */
// analog core model: rc oscillator ticks and conversion completion
module ais_core_model #(
  parameter int CONV_CYCLES = 4,
  parameter int RC_PERIOD = 5
) (
  input wire logic core_clk, // system clock
  input wire logic rst_n, // synchronous reset, active low
  input wire logic convert_start, // conversion request pulse
  output logic rc_clk_tick, // one-cycle rc oscillator tick
  output logic convert_done // one-cycle completion pulse
);
  timeunit 1ns;
  timeprecision 1ps;
  int rc_cnt;
  int conv_cnt;
  // rc oscillator runs free, unrelated to conversions, as the real one does
  always_ff @(posedge core_clk) begin
    if (!rst_n || rc_cnt == RC_PERIOD) begin
      rc_cnt <= 0;
    end else begin
      rc_cnt <= rc_cnt + 1;
    end
  end
  assign rc_clk_tick = rst_n && rc_cnt == RC_PERIOD;
  // fixed conversion time; a larger count models a slow core
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      conv_cnt <= 0;
    end else if (convert_start) begin
      conv_cnt <= CONV_CYCLES;
    end else if (conv_cnt > 0) begin
      conv_cnt <= conv_cnt - 1;
    end
  end
  assign convert_done = conv_cnt == 1;
endmodule

/* verification/adc_input_select_timing_bench.sv */
// self-checking bench for the converter input select and timing block
module adc_input_select_timing_bench;
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------
  // signals, clock and models
  // ----------------------------------------
  logic core_clk = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [31:0] paddr = 32'h0, pwdata = 32'h0, prdata, r, seed = 32'h9b3b;
  logic pready, pslverr, rc_clk_tick, convert_done, sampling, convert_start, conv_clock_period;
  logic [4:0] primary_pos_sel, primary_neg_sel, p1, aux_pos_sel [3], aux_neg_sel [3];
  logic [7:0] buffer_words_per_input;
  logic resolution_mode;
  logic [32:0] exp_q [$];
  logic [7:0] adr [5] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10};
  logic [15:0] msk [5] = '{16'h9fff, 16'h0007, 16'h0707, 16'h9f9f, 16'h1fff};
  int error_cnt = 0, samples_checked = 0, cycles = 0, g1, g2;
  always #2 core_clk = ~core_clk; // 250 mhz
  ais_top DUT (.core_clk, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .rc_clk_tick, .convert_done, .sampling, .convert_start, .conv_clock_period,
    .primary_pos_sel, .primary_neg_sel, .aux_pos_sel, .aux_neg_sel, .buffer_words_per_input,
    .resolution_mode);
  ais_core_model core (.core_clk, .rst_n, .convert_start, .rc_clk_tick, .convert_done);
  // cycle count used for gap measurement and as the hang limit
  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (cycles == 30000) begin
      error_cnt++;
      end_of_test();
    end
  end
  // read monitor: data taken at the edge that completes the access
  always @(posedge core_clk) begin
    if (psel && penable && pready && !pwrite && exp_q.size() > 0) begin
      check(prdata, exp_q[0][31:0], "read data");
      check({31'h0, pslverr}, {31'h0, exp_q[0][32]}, "error flag");
      void'(exp_q.pop_front());
    end
  end
  // ----------------------------------------
  // tasks
  // ----------------------------------------
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  task automatic check(input logic [31:0] act, input logic [31:0] exp, input string what);
    samples_checked++;
    if (act !== exp) begin
      error_cnt++;
      $display("CHECK FAILED at %0t: %s got %h expected %h", $time, what, act, exp);
    end
  endtask
  // request held until pready is seen high at a rising edge
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= {24'h0, a};
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    // only the bench's cycle limit may end this wait
    do @(posedge core_clk); while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic err);
    exp_q.push_back({err, e});
    apb(1'b0, a, 32'h0);
  endtask
  task automatic settle();
    repeat (2) @(negedge core_clk);
  endtask
  task automatic wait_hi(ref logic s);
    int n;
    n = 0;
    @(negedge core_clk);
    while (s !== 1'b1 && n++ < 3000) @(negedge core_clk);
    if (n >= 3000) check(32'h0, 32'h1, "wait too long");
  endtask
  task automatic period(output int g);
    int t0;
    // the first pulse may still belong to the previous clock setting
    wait_hi(conv_clock_period);
    wait_hi(conv_clock_period);
    t0 = cycles;
    wait_hi(conv_clock_period);
    g = cycles - t0;
  endtask
  // software trigger: sampling must outlast the programmed sample time
  task automatic conv_sw(input logic [7:0] c);
    apb(1'b1, ais_pkg::ADDR_CTRL, {24'h0, c | 8'h80});
    repeat (20) @(negedge core_clk);
    check({31'h0, sampling}, 32'h1, "sampling held");
    apb(1'b1, ais_pkg::ADDR_CTRL, {24'h0, c});
    wait_hi(convert_done);
    settle();
  endtask
  task automatic end_of_test();
    $display("checks %0d errors %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  // ----------------------------------------
  // test sequence
  // ----------------------------------------
  initial begin
    repeat (8) @(posedge core_clk);
    rst_n <= 1'b1;
    for (int i = 0; i < 5; i++) begin
      rd(adr[i], 32'h0, 1'b0);
      apb(1'b1, adr[i], 32'hffffffff);
      rd(adr[i], {16'h0, msk[i]}, 1'b0);
      apb(1'b1, adr[i], 32'h0);
    end
    rd(8'h1c, 32'h0, 1'b1);
    for (int c = 0; c < 8; c++) begin
      apb(1'b1, ais_pkg::ADDR_DEPTH, 32'(c));
      settle();
      check({24'h0, buffer_words_per_input}, 32'h1 << c, "buffer words");
    end
    for (int c = 0; c < 8; c++) begin
      r = rnd();
      apb(1'b1, ais_pkg::ADDR_AUX_SEL, {21'h0, r[2:0], 5'h0, c[2:0]});
      settle();
      for (int i = 0; i < 3; i++) begin
        check({27'h0, aux_pos_sel[i]}, c[0] ? i + 3 : i, "aux pos");
        g1 = c[2:1] == 3 ? i + 9 : (c[2:1] == 2 ? i + 6 : 31);
        check({27'h0, aux_neg_sel[i]}, g1, "aux neg");
      end
    end
    for (int k = 0; k < 8; k++) begin
      r = rnd();
      r[4:0] = k == 0 ? 5'h0c : 5'(r[7:0] % 13);
      apb(1'b1, ais_pkg::ADDR_PRI_SEL, {16'h0, r[31:24], r[8], 2'h0, r[4:0]});
      settle();
      check({27'h0, primary_pos_sel}, {27'h0, r[4:0]}, "pri pos");
      check({27'h0, primary_neg_sel}, r[8] ? 32'h1 : 32'h1f, "pri neg");
    end
    apb(1'b1, ais_pkg::ADDR_CTRL, 32'h40);
    apb(1'b1, ais_pkg::ADDR_PRI_SEL, 32'h7);
    settle();
    check({27'h0, primary_pos_sel}, 32'h1f, "small variant");
    apb(1'b1, ais_pkg::ADDR_CTRL, 32'h0);
    apb(1'b1, ais_pkg::ADDR_TIMING, 32'h0302);
    period(g1);
    check(g1, 3, "period");
    apb(1'b1, ais_pkg::ADDR_CTRL, 32'hb8);
    wait_hi(sampling);
    g2 = 0;
    while (sampling === 1'b1 && g2 < 99) begin
      g2 += int'(conv_clock_period === 1'b1);
      @(negedge core_clk);
    end
    check(g2, 3, "sample periods");
    @(negedge core_clk);
    check({31'h0, convert_start}, 32'h1, "start pulse");
    apb(1'b1, ais_pkg::ADDR_CTRL, 32'h38);
    wait_hi(convert_done);
    apb(1'b1, ais_pkg::ADDR_TIMING, 32'h8102);
    period(g1);
    apb(1'b1, ais_pkg::ADDR_TIMING, 32'h8109);
    period(g2);
    check(g1, g2, "rc period");
    check({31'h0, g1 != 3}, 32'h1, "rc source");
    apb(1'b1, ais_pkg::ADDR_TIMING, 32'h0100);
    apb(1'b1, ais_pkg::ADDR_AUX_SEL, 32'h0704);
    apb(1'b1, ais_pkg::ADDR_PRI_SEL, 32'h8a03);
    conv_sw(8'h02);
    check({27'h0, primary_pos_sel}, 32'ha, "pri pos b");
    check({27'h0, primary_neg_sel}, 32'h1, "pri neg b");
    check({27'h0, aux_pos_sel[2]}, 32'h5, "aux pos b");
    check({27'h0, aux_neg_sel[2]}, 32'hb, "aux neg b");
    conv_sw(8'h02);
    check({27'h0, primary_pos_sel}, 32'h3, "pri pos a");
    apb(1'b1, ais_pkg::ADDR_SCAN, 32'h0024);
    conv_sw(8'h04);
    p1 = primary_pos_sel;
    conv_sw(8'h04);
    g1 = int'((p1 == 2 || p1 == 5) && (primary_pos_sel == 2 || primary_pos_sel == 5));
    check(g1 + int'(p1 != primary_pos_sel), 2, "scan step");
    apb(1'b1, ais_pkg::ADDR_CTRL, 32'h1);
    rd(ais_pkg::ADDR_AUX_SEL, 32'h0, 1'b0);
    settle();
    check({31'h0, resolution_mode}, 32'h1, "resolution");
    end_of_test();
  end
endmodule
